// ### logic/ahbp_pkg.sv
package ahbp_pkg;

	// ************************************************************
	// transfer type and burst encodings
	// ************************************************************
	localparam logic [1:0] TR_IDLE = 2'h0;
	localparam logic [1:0] TR_BUSY = 2'h1;
	localparam logic [1:0] TR_NONSEQ = 2'h2;
	localparam logic [1:0] TR_SEQ = 2'h3;

	localparam logic [2:0] BU_SINGLE = 3'h0;
	localparam logic [2:0] BU_INCR = 3'h1;
	localparam logic [2:0] BU_WRAP4 = 3'h2;
	localparam logic [2:0] BU_INCR4 = 3'h3;
	localparam logic [2:0] BU_WRAP8 = 3'h4;
	localparam logic [2:0] BU_INCR8 = 3'h5;
	localparam logic [2:0] BU_WRAP16 = 3'h6;
	localparam logic [2:0] BU_INCR16 = 3'h7;

	// beats still to come after the first beat of a fixed burst
	localparam logic [4:0] LEFT_NONE = 5'h00;
	localparam logic [4:0] LEFT_AFTER4 = 5'h03;
	localparam logic [4:0] LEFT_AFTER8 = 5'h07;
	localparam logic [4:0] LEFT_AFTER16 = 5'h0f;

	// ************************************************************
	// response encoding and values after reset
	// ************************************************************
	localparam logic RESP_OKAY = 1'b0;
	localparam logic RESP_ERROR = 1'b1;
	localparam logic READY_RST = 1'b1;

	// ************************************************************
	// port sequencer states, gray coded along idle-addr-data
	// ************************************************************
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ADDR = 2'b01,
		ST_DATA = 2'b11,
		ST_ERR = 2'b10
	} ahbp_state_t;

endpackage : ahbp_pkg

// ### logic/ahbp_resp_mux.sv
`timescale 1ns/100ps
module ahbp_resp_mux #(
	parameter int SLV_N = 2,
	parameter int DATA_W = 32,
	parameter int RU_W = 1,
	parameter int SEL_W = 1
) (
	// slave selected for the current data phase
	input wire logic [SEL_W-1:0] sel,
	// responses from every slave
	input wire logic [SLV_N-1:0] readyIn,
	input wire logic [SLV_N-1:0] respIn,
	input wire logic [SLV_N*DATA_W-1:0] rdataIn,
	input wire logic [SLV_N*RU_W-1:0] ruserIn,
	// the one answer handed on
	output logic readyOut,
	output logic respOut,
	output logic [DATA_W-1:0] rdataOut,
	output logic [RU_W-1:0] ruserOut
);
	// ************************************************************
	// select the data-phase slave; an unknown index answers ready
	// ************************************************************
	always_comb begin
		readyOut = 1'b1;
		respOut = 1'b0;
		rdataOut = '0;
		ruserOut = '0;
		for (int i = 0; i < SLV_N; i++) begin
			if (sel == SEL_W'(i)) begin
				readyOut = readyIn[i];
				respOut = respIn[i];
				rdataOut = rdataIn[i*DATA_W +: DATA_W];
				ruserOut = ruserIn[i*RU_W +: RU_W];
			end
		end
	end
endmodule : ahbp_resp_mux

// ### logic/ahbp_port.sv
`timescale 1ns/100ps
module ahbp_port
	import ahbp_pkg::*;
#(
	parameter int ADDR_W = 32,
	parameter int DATA_W = 32,
	parameter int AUSER_W = 0,
	parameter int WUSER_W = 0,
	parameter int RUSER_W = 0,
	parameter int SLV_N = 2,
	parameter int SEL_LSB = 28
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// from the upstream master
	input wire logic upSel,
	input wire logic upHready,
	input wire logic [ADDR_W-1:0] upAddr,
	input wire logic [1:0] upTrans,
	input wire logic upWrite,
	input wire logic [2:0] upSize,
	input wire logic [2:0] upBurst,
	input wire logic [3:0] upProt,
	input wire logic upMastlock,
	input wire logic [DATA_W-1:0] upWdata,
	input wire logic [(AUSER_W>0?AUSER_W:1)-1:0] upAuser,
	input wire logic [(WUSER_W>0?WUSER_W:1)-1:0] upWuser,
	// back to the upstream master
	output logic upReadyOutQ,
	output logic upRespQ,
	output logic [DATA_W-1:0] upRdataQ,
	output logic [(RUSER_W>0?RUSER_W:1)-1:0] upRuserQ,
	// toward the downstream slaves
	output logic [SLV_N-1:0] dnSelQ,
	output logic dnHready,
	output logic [ADDR_W-1:0] dnAddrQ,
	output logic [1:0] dnTransQ,
	output logic dnWriteQ,
	output logic [2:0] dnSizeQ,
	output logic [2:0] dnBurstQ,
	output logic [3:0] dnProtQ,
	output logic dnMastlockQ,
	output logic [DATA_W-1:0] dnWdataQ,
	output logic [(AUSER_W>0?AUSER_W:1)-1:0] dnAuserQ,
	output logic [(WUSER_W>0?WUSER_W:1)-1:0] dnWuserQ,
	// answers from the downstream slaves
	input wire logic [SLV_N-1:0] dnReadyOut,
	input wire logic [SLV_N-1:0] dnResp,
	input wire logic [SLV_N*DATA_W-1:0] dnRdata,
	input wire logic [SLV_N*(RUSER_W>0?RUSER_W:1)-1:0] dnRuser
);
	localparam int AU_E = AUSER_W > 0 ? AUSER_W : 1;
	localparam int WU_E = WUSER_W > 0 ? WUSER_W : 1;
	localparam int RU_E = RUSER_W > 0 ? RUSER_W : 1;
	localparam int SEL_W = SLV_N > 1 ? $clog2(SLV_N) : 1;

	ahbp_state_t stateQ, stateD;
	logic [SEL_W-1:0] dataIdxQ, dataIdxD;
	logic [4:0] leftQ, leftD;
	logic [SLV_N-1:0] dnSelD;
	logic [ADDR_W-1:0] dnAddrD;
	logic [1:0] dnTransD;
	logic dnWriteD, dnMastlockD, accept;
	logic [2:0] dnSizeD, dnBurstD;
	logic [3:0] dnProtD;
	logic [DATA_W-1:0] dnWdataD, upRdataD;
	logic [AU_E-1:0] dnAuserD;
	logic [WU_E-1:0] dnWuserD;
	logic [RU_E-1:0] upRuserD;
	logic upReadyOutD, upRespD, muxReady, muxResp;
	logic [DATA_W-1:0] muxRdata;
	logic [RU_E-1:0] muxRuser;
	logic [SEL_W-1:0] addrIdx;

	// ************************************************************
	// response multiplexer over the slaves
	// ************************************************************
	ahbp_resp_mux #(
		.SLV_N(SLV_N),
		.DATA_W(DATA_W),
		.RU_W(RU_E),
		.SEL_W(SEL_W)
	) uRespMux (
		.sel(dataIdxQ),
		.readyIn(dnReadyOut),
		.respIn(dnResp),
		.rdataIn(dnRdata),
		.ruserIn(dnRuser),
		.readyOut(muxReady),
		.respOut(muxResp),
		.rdataOut(muxRdata),
		.ruserOut(muxRuser)
	);

	// shared ready must follow the data-phase slave in the same cycle,
	// so it cannot come from a flop without breaking slave handshakes
	assign dnHready = muxReady;

	// a transfer is taken only when the shared ready says the last ended
	assign accept = upSel && upHready && upReadyOutQ && upTrans[1];
	assign addrIdx = upAddr[SEL_LSB +: SEL_W];

	// ************************************************************
	// sequencer: take upstream beat, replay it downstream, answer
	// ************************************************************
	always_comb begin
		stateD = stateQ;
		dataIdxD = dataIdxQ;
		leftD = leftQ;
		dnSelD = dnSelQ;
		dnAddrD = dnAddrQ;
		dnTransD = dnTransQ;
		dnWriteD = dnWriteQ;
		dnSizeD = dnSizeQ;
		dnBurstD = dnBurstQ;
		dnProtD = dnProtQ;
		dnMastlockD = dnMastlockQ;
		dnAuserD = dnAuserQ;
		dnWdataD = dnWdataQ;
		dnWuserD = dnWuserQ;
		upReadyOutD = upReadyOutQ;
		upRespD = upRespQ;
		upRdataD = upRdataQ;
		upRuserD = upRuserQ;
		unique case (stateQ)
			ST_IDLE: begin
				upRespD = RESP_OKAY;
				if (accept) begin
					stateD = ST_ADDR;
					upReadyOutD = 1'b0;
					dnSelD = '0;
					dnSelD[addrIdx] = 1'b1;
					dnAddrD = upAddr;
					dnTransD = upTrans;
					dnWriteD = upWrite;
					dnSizeD = upSize;
					dnBurstD = upBurst;
					dnProtD = upProt;
					dnMastlockD = upMastlock;
					// address user bits go out with the address
					dnAuserD = AUSER_W > 0 ? upAuser : '0;
					if (upTrans == TR_NONSEQ) begin
						unique case (upBurst)
							BU_WRAP4, BU_INCR4: leftD = LEFT_AFTER4;
							BU_WRAP8, BU_INCR8: leftD = LEFT_AFTER8;
							BU_WRAP16, BU_INCR16: leftD = LEFT_AFTER16;
							default: leftD = LEFT_NONE;
						endcase
					end else if (leftQ != LEFT_NONE) begin
						leftD = leftQ - 5'h01;
					end
				end else if (upSel && upHready && !upMastlock) begin
					dnMastlockD = 1'b0; // lock ends with an unlocked beat
				end
			end
			ST_ADDR: begin
				if (muxReady) begin
					stateD = ST_DATA;
					dataIdxD = dnAddrQ[SEL_LSB +: SEL_W];
					// fixed burst with beats left keeps the burst alive
					dnTransD = leftQ != LEFT_NONE ? TR_BUSY : TR_IDLE;
					// master holds write data while we stall its data phase
					dnWdataD = upWdata;
					dnWuserD = WUSER_W > 0 ? upWuser : '0;
				end
			end
			ST_DATA: begin
				if (muxReady) begin
					upRdataD = muxRdata;
					upRuserD = RUSER_W > 0 ? muxRuser : '0;
					if (muxResp == RESP_ERROR) begin
						stateD = ST_ERR;
						upRespD = RESP_ERROR;
					end else begin
						stateD = ST_IDLE;
						upReadyOutD = 1'b1;
						upRespD = RESP_OKAY;
					end
				end
			end
			ST_ERR: begin
				// second error cycle; the master may drop the burst
				stateD = ST_IDLE;
				upReadyOutD = 1'b1;
				leftD = LEFT_NONE;
				dnTransD = TR_IDLE;
			end
		endcase
	end

	// ************************************************************
	// state registers
	// ************************************************************
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			stateQ <= ST_IDLE;
			dataIdxQ <= '0;
			leftQ <= LEFT_NONE;
			dnSelQ <= '0;
			dnAddrQ <= '0;
			dnTransQ <= TR_IDLE;
			dnWriteQ <= 1'b0;
			dnSizeQ <= '0;
			dnBurstQ <= BU_SINGLE;
			dnProtQ <= '0;
			dnMastlockQ <= 1'b0;
			dnAuserQ <= '0;
			dnWdataQ <= '0;
			dnWuserQ <= '0;
			upReadyOutQ <= READY_RST;
			upRespQ <= RESP_OKAY;
			upRdataQ <= '0;
			upRuserQ <= '0;
		end else begin
			stateQ <= stateD;
			dataIdxQ <= dataIdxD;
			leftQ <= leftD;
			dnSelQ <= dnSelD;
			dnAddrQ <= dnAddrD;
			dnTransQ <= dnTransD;
			dnWriteQ <= dnWriteD;
			dnSizeQ <= dnSizeD;
			dnBurstQ <= dnBurstD;
			dnProtQ <= dnProtD;
			dnMastlockQ <= dnMastlockD;
			dnAuserQ <= dnAuserD;
			dnWdataQ <= dnWdataD;
			dnWuserQ <= dnWuserD;
			upReadyOutQ <= upReadyOutD;
			upRespQ <= upRespD;
			upRdataQ <= upRdataD;
			upRuserQ <= upRuserD;
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	chk_error_two_cycle: assert property (
		upRespQ && !upReadyOutQ |=> upRespQ && upReadyOutQ ##1 !upRespQ
	) else $error("error response not two cycles");

	chk_okay_pass_mux: assert property (
		stateQ == ST_DATA && muxReady && !muxResp |=>
			upReadyOutQ && !upRespQ && upRdataQ == $past(muxRdata)
	) else $error("okay response not passed to master");

	chk_user_zero_w: assert property (
		(AUSER_W != 0 || dnAuserQ == '0)
			&& (WUSER_W != 0 || dnWuserQ == '0)
			&& (RUSER_W != 0 || upRuserQ == '0)
	) else $error("unused sideband not zero");

	chk_wuser_follow: assert property (
		stateQ == ST_ADDR && muxReady |=>
			dnWdataQ == $past(upWdata)
			&& (WUSER_W == 0 || dnWuserQ == $past(upWuser))
	) else $error("write user bits lost");

	chk_ruser_return: assert property (
		stateQ == ST_DATA && muxReady |=>
			(RUSER_W == 0 || upRuserQ == $past(muxRuser))
	) else $error("read user bits lost");

	chk_addr_forward: assert property (
		accept |=> stateQ == ST_ADDR && dnAddrQ == $past(upAddr)
			&& dnTransQ == $past(upTrans)
			&& (AUSER_W == 0 || dnAuserQ == $past(upAuser))
	) else $error("address phase not forwarded");

	chk_burst_gap: assert property (
		stateQ == ST_DATA && leftQ != LEFT_NONE |-> dnTransQ == TR_BUSY
	) else $error("fixed burst broken between beats");

	chk_lock_hold: assert property (
		accept && upMastlock |=> dnMastlockQ [*2]
	) else $error("locked transfer not held");

	chk_accept_stall: assert property (
		accept |=> !upReadyOutQ ##1 !upReadyOutQ
	) else $error("upstream not stalled after accept");

endmodule : ahbp_port

// ### dv/ahbp_slave_model.sv
`timescale 1ns/100ps
module ahbp_slave_model
	import ahbp_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// from the port
	input wire logic [1:0] dnSelQ,
	input wire logic dnHready,
	input wire logic [31:0] dnAddrQ,
	input wire logic [1:0] dnTransQ,
	input wire logic dnWriteQ,
	input wire logic [2:0] dnBurstQ,
	input wire logic dnMastlockQ,
	input wire logic [31:0] dnWdataQ,
	input wire logic [7:0] dnAuserQ,
	input wire logic [7:0] dnWuserQ,
	// answers of both slaves
	output logic [1:0] dnReadyOut,
	output logic [1:0] dnResp,
	output logic [63:0] dnRdata,
	output logic [15:0] dnRuser,
	// bench controls and what was seen
	input wire logic [3:0] waitN,
	input wire logic errOn,
	output logic [31:0] seenAddr,
	output logic [31:0] seenWdata,
	output logic [7:0] seenAuser,
	output logic [7:0] seenWuser,
	output logic seenLock,
	output logic [2:0] seenBurst,
	output int beats
);
	// ************************************************************
	// two slaves sharing one data-phase tracker
	// ************************************************************
	logic act_q, err_q, tail_q, who_q, wr_q, rdy;
	logic [3:0] cnt_q;
	logic [31:0] rd_q;
	logic [7:0] ru_q;
	// an idle slave shows the inverse of its last data, so stale
	// values cannot slip through as a match
	always_comb begin
		rdy = (cnt_q == 4'h0) && !(err_q && !tail_q);
		dnReadyOut = 2'h3;
		dnResp = 2'h0;
		dnRdata = {~rd_q, ~rd_q};
		dnRuser = {~ru_q, ~ru_q};
		if (act_q) begin
			dnReadyOut[who_q] = rdy;
			dnResp[who_q] = err_q;
			if (rdy && !err_q && !wr_q) begin
				dnRdata[who_q*32 +: 32] = seenAddr ^ 32'ha5a50000;
				dnRuser[who_q*8 +: 8] = seenAuser ^ 8'h0f;
			end
		end
	end
	// address taken on ready, data phase stalls waitN cycles
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			act_q <= 1'b0;
			cnt_q <= 4'h0;
			err_q <= 1'b0;
			tail_q <= 1'b0;
			beats <= 0;
		end else begin
			if (act_q && dnHready && rdy) begin
				act_q <= 1'b0;
				beats <= beats + 1;
				rd_q <= seenAddr ^ 32'ha5a50000;
				ru_q <= seenAuser ^ 8'h0f;
				if (wr_q) begin
					seenWdata <= dnWdataQ;
					seenWuser <= dnWuserQ;
				end
			end else if (act_q && cnt_q != 4'h0)
				cnt_q <= cnt_q - 4'h1;
			else if (act_q && err_q)
				tail_q <= 1'b1;
			if (|dnSelQ && dnTransQ[1] && dnHready) begin
				act_q <= 1'b1;
				who_q <= dnSelQ[1];
				wr_q <= dnWriteQ;
				cnt_q <= waitN;
				err_q <= errOn;
				tail_q <= 1'b0;
				seenAddr <= dnAddrQ;
				seenAuser <= dnAuserQ;
				seenLock <= dnMastlockQ;
				seenBurst <= dnBurstQ;
			end
		end
	end
endmodule : ahbp_slave_model

// ### dv/ahbp_port_test.sv
`timescale 1ns/100ps
module ahbp_port_test;
	import ahbp_pkg::*;
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic upSel, upWrite, upMastlock, upReadyOutQ, upRespQ, dnHready;
	logic [31:0] upAddr, upWdata, upRdataQ, dnAddrQ, dnWdataQ;
	logic [1:0] upTrans, dnTransQ, dnSelQ, dnReadyOut, dnResp;
	logic [2:0] upBurst, dnSizeQ, dnBurstQ;
	logic [7:0] upAuser, upWuser, upRuserQ, dnAuserQ, dnWuserQ;
	logic dnWriteQ, dnMastlockQ, errOn, sLock;
	logic [3:0] dnProtQ, waitN;
	logic [63:0] dnRdata;
	logic [15:0] dnRuser;
	logic [31:0] sAddr, sWdata;
	logic [7:0] sAuser, sWuser;
	logic [2:0] sBurst;
	logic zRuser, zAuser, zWuser;
	int beats, n, b0, fails, samples_checked;
	logic [2:0] buT[3] = '{BU_INCR4, BU_WRAP8, BU_INCR16};
	int lenT[3] = '{4, 8, 16};

	always #2 sys_clk = ~sys_clk;
	// one master upstream, so its shared ready is our own readyout
	logic upHready;
	assign upHready = upReadyOutQ;

	ahbp_port #(.AUSER_W(8), .WUSER_W(8), .RUSER_W(8)) dut (
		.sys_clk(sys_clk), .resetn(resetn), .upSel(upSel),
		.upHready(upHready), .upAddr(upAddr), .upTrans(upTrans),
		.upWrite(upWrite), .upSize(3'h2), .upBurst(upBurst),
		.upProt(4'h3), .upMastlock(upMastlock), .upWdata(upWdata),
		.upAuser(upAuser), .upWuser(upWuser),
		.upReadyOutQ(upReadyOutQ), .upRespQ(upRespQ),
		.upRdataQ(upRdataQ), .upRuserQ(upRuserQ), .dnSelQ(dnSelQ),
		.dnHready(dnHready), .dnAddrQ(dnAddrQ), .dnTransQ(dnTransQ),
		.dnWriteQ(dnWriteQ), .dnSizeQ(dnSizeQ), .dnBurstQ(dnBurstQ),
		.dnProtQ(dnProtQ), .dnMastlockQ(dnMastlockQ),
		.dnWdataQ(dnWdataQ), .dnAuserQ(dnAuserQ),
		.dnWuserQ(dnWuserQ), .dnReadyOut(dnReadyOut),
		.dnResp(dnResp), .dnRdata(dnRdata), .dnRuser(dnRuser));

	// a second port with every sideband at width zero follows the same
	// upstream beats; its slaves always answer ready and okay, and the
	// tied-high user bits must never show through
	ahbp_port dutNoUser (
		.sys_clk(sys_clk), .resetn(resetn), .upSel(upSel),
		.upHready(upHready), .upAddr(upAddr), .upTrans(upTrans),
		.upWrite(upWrite), .upSize(3'h2), .upBurst(upBurst),
		.upProt(4'h3), .upMastlock(upMastlock), .upWdata(upWdata),
		.upAuser(upAuser[0]), .upWuser(upWuser[0]),
		.upReadyOutQ(), .upRespQ(), .upRdataQ(),
		.upRuserQ(zRuser), .dnSelQ(), .dnHready(), .dnAddrQ(),
		.dnTransQ(), .dnWriteQ(), .dnSizeQ(), .dnBurstQ(),
		.dnProtQ(), .dnMastlockQ(), .dnWdataQ(),
		.dnAuserQ(zAuser), .dnWuserQ(zWuser),
		.dnReadyOut(2'h3), .dnResp(2'h0), .dnRdata(dnRdata),
		.dnRuser(2'h3));

	ahbp_slave_model slaves (
		.sys_clk(sys_clk), .resetn(resetn), .dnSelQ(dnSelQ),
		.dnHready(dnHready), .dnAddrQ(dnAddrQ), .dnTransQ(dnTransQ),
		.dnWriteQ(dnWriteQ), .dnBurstQ(dnBurstQ),
		.dnMastlockQ(dnMastlockQ), .dnWdataQ(dnWdataQ),
		.dnAuserQ(dnAuserQ), .dnWuserQ(dnWuserQ),
		.dnReadyOut(dnReadyOut), .dnResp(dnResp), .dnRdata(dnRdata),
		.dnRuser(dnRuser), .waitN(waitN), .errOn(errOn),
		.seenAddr(sAddr), .seenWdata(sWdata), .seenAuser(sAuser),
		.seenWuser(sWuser), .seenLock(sLock), .seenBurst(sBurst),
		.beats(beats));

	// ************************************************************
	// bench tasks
	// ************************************************************
	task automatic chk(input string nm, input logic [31:0] e, g);
		samples_checked++;
		if (g !== e) begin
			fails++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic report_and_stop;
		$display("checked %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : report_and_stop

	// one beat, entered at a falling edge with readyout high; write
	// data follows a cycle later and is held until readyout returns
	task automatic beat(input logic w, input logic [31:0] a,
		input logic [1:0] tr, gap, input logic [2:0] bu,
		input logic lk, input logic [7:0] au);
		upTrans = tr;
		upAddr = a;
		upWrite = w;
		upBurst = bu;
		upMastlock = lk;
		upAuser = au;
		@(negedge sys_clk);
		upTrans = gap;
		upWdata = a ^ 32'h0f0f0f0f;
		upWuser = au + 8'h11;
		n = 0;
		while (!upReadyOutQ && n < 64) begin
			@(negedge sys_clk);
			n++;
		end
		if (n == 64) begin
			fails++;
			report_and_stop();
		end
	endtask : beat

	initial begin
		{upSel, upWrite, upMastlock, errOn} = 4'h8;
		{upAddr, upWdata, upAuser, upWuser} = '0;
		{upTrans, upBurst, waitN} = '0;
		repeat (8) @(posedge sys_clk);
		chk("ready", 1, upReadyOutQ);
		chk("resp", RESP_OKAY, upRespQ);
		chk("trans", TR_IDLE, dnTransQ);
		chk("sel", 0, dnSelQ);
		@(negedge sys_clk);
		resetn = 1'b1;
		$display("test reset done");
		beat(1, 32'hd0000044, TR_NONSEQ, TR_IDLE, BU_SINGLE, 0, 8'h5c);
		chk("addr", 32'hd0000044, sAddr);
		chk("auser", 8'h5c, sAuser);
		chk("wdata", 32'hdf0f0f4b, sWdata);
		chk("wuser", 8'h6d, sWuser);
		chk("wresp", RESP_OKAY, upRespQ);
		chk("wlat", 2, n);
		chk("size", 3'h2, dnSizeQ);
		chk("prot", 4'h3, dnProtQ);
		chk("zwuser", 0, zWuser);
		$display("test write done");
		waitN = 4'h3;
		beat(0, 32'h20000080, TR_NONSEQ, TR_IDLE, BU_SINGLE, 0, 8'h33);
		chk("stall", 5, n);
		chk("rdata", 32'h85a50080, upRdataQ);
		chk("ruser", 8'h3c, upRuserQ);
		chk("zauser", 0, zAuser);
		chk("zruser", 0, zRuser);
		$display("test read done");
		{waitN, errOn} = 5'h01;
		beat(0, 32'h10000000, TR_NONSEQ, TR_IDLE, BU_SINGLE, 0, 8'h00);
		chk("eresp", RESP_ERROR, upRespQ);
		errOn = 1'b0;
		beat(1, 32'h10000004, TR_NONSEQ, TR_IDLE, BU_SINGLE, 0, 8'h01);
		chk("oresp", RESP_OKAY, upRespQ);
		$display("test error done");
		// every fixed length, the first one locked
		for (int i = 0; i < 3; i++) begin
			b0 = beats;
			for (int k = 0; k < lenT[i]; k++) begin
				beat(0, 32'h20000100 + 32'(4 * k),
					(k == 0) ? TR_NONSEQ : TR_SEQ,
					(k == lenT[i] - 1) ? TR_IDLE : TR_BUSY,
					buT[i], i == 0, 8'(k));
			end
			chk("beats", lenT[i], beats - b0);
			chk("burst", buT[i], sBurst);
			chk("lock", i == 0, sLock);
		end
		$display("test burst done");
		report_and_stop();
	end
endmodule : ahbp_port_test
